// File: inc/pad_pkg.sv
// constants for the programmable address decoder
package pad_pkg;
	// ------------------------------------------------------------
	// decode input vector layout
	// ------------------------------------------------------------
	localparam int unsigned N_IN = 16;
	localparam int unsigned IN_ADDR_LO = 0;    // a11..a15
	localparam int unsigned IN_ADDR_W = 5;
	localparam int unsigned IN_HIGH_LO = 5;    // a16..a18 from port c
	localparam int unsigned IN_A19 = 8;
	localparam int unsigned IN_PAGE_LO = 9;    // page_bits 0..3
	localparam int unsigned IN_PAGE_W = 4;
	localparam int unsigned IN_READ = 13;
	localparam int unsigned IN_WRITE = 14;
	localparam int unsigned IN_ALE = 15;
	// ------------------------------------------------------------
	// product term slots
	// ------------------------------------------------------------
	localparam int unsigned N_EPROM = 8;
	localparam int unsigned N_WIDE = 4;
	localparam int unsigned N_WIDE_PT = 4;
	localparam int unsigned N_NARROW = 4;
	localparam int unsigned N_NARROW_PT = 2;
	localparam int unsigned N_PORTC = 3;
	localparam int unsigned PT_EPROM = 0;
	localparam int unsigned PT_SRAM = 8;
	localparam int unsigned PT_IOSPACE = 9;
	localparam int unsigned PT_TRACK_RD = 10;
	localparam int unsigned PT_TRACK_AO = 11;
	localparam int unsigned PT_TRACK_WO = 12;
	localparam int unsigned PT_WIDE = 13;
	localparam int unsigned PT_NARROW = 29;
	localparam int unsigned PT_PORTC = 37;
	localparam int unsigned N_PT = 40;
	localparam logic [5:0] IDX_MODE = 6'h28;
	// ------------------------------------------------------------
	// mode word fields
	// ------------------------------------------------------------
	localparam int unsigned MODE_W = 13;
	localparam int unsigned MODE_STANDBY = 0;
	localparam int unsigned MODE_PORTC_LO = 1;
	localparam int unsigned MODE_PORTB_LO = 4;
	localparam int unsigned MODE_TRACK = 12;
	localparam logic [MODE_W-1:0] MODE_RESET = 13'h0000;
	localparam int unsigned BUS_W = 8;
	localparam int unsigned PORTB_W = 8;
	// synchroniser vector: addr5 a19 page4 rd wr ale portc3 ad8 porta8
	localparam int unsigned SYN_W = 32;
	localparam int unsigned SY_ADDR = 0;
	localparam int unsigned SY_A19 = 5;
	localparam int unsigned SY_PAGE = 6;
	localparam int unsigned SY_RD = 10;
	localparam int unsigned SY_WR = 11;
	localparam int unsigned SY_ALE = 12;
	localparam int unsigned SY_PORTC = 13;
	localparam int unsigned SY_AD = 16;
	localparam int unsigned SY_PORTA = 24;
endpackage : pad_pkg

// File: rtl/pad_product_term.sv
// one programmable product term: care mask, match value, enable
`timescale 1ns/1ps
module pad_product_term (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_we,
	input wire logic [pad_pkg::N_IN-1:0] i_care,
	input wire logic [pad_pkg::N_IN-1:0] i_match,
	input wire logic i_enable,
	input wire logic [pad_pkg::N_IN-1:0] i_vec,
	output logic o_hit
);
	logic [pad_pkg::N_IN-1:0] care_ff;
	logic [pad_pkg::N_IN-1:0] match_ff;
	logic enable_ff;

	// erased term never fires
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			care_ff <= 16'h0000;
			match_ff <= 16'h0000;
			enable_ff <= 1'b0;
		end else if (i_we) begin
			care_ff <= i_care;
			match_ff <= i_match;
			enable_ff <= i_enable;
		end
	end

	// and of selected literals only
	always_comb begin
		o_hit = enable_ff && (((i_vec ^ match_ff) & care_ff) == 16'h0000);
	end
endmodule : pad_product_term

// File: rtl/pad_decoder.sv
// programmable address decoder with internal and external arrays
//
// Contract
// - reset deselects all; never a decode term
// - eight eprom bank selects, one term each
// - bank boundary is any single-term address match
// - one sram select from one term
// - port register space select from one term
// - track read select gated by read strobe
// - track address out gated by latch strobe
// - track write out term holds write terms
// - four wide selects, or of four terms
// - four narrow selects, or of two terms
// - three port c selects, one term each
// - latch strobe is a decode input
// - read strobe is a decode input
// - write strobe is a decode input
// - ports b and c configurable per bit; port a has one enable
// - standby high deselects all, else address
// - port c pins shared, per-bit direction
// - both arrays see identical inputs
`timescale 1ns/1ps
module pad_decoder (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [4:0] i_addr_high,
	input wire logic i_standby_or_high_addr,
	input wire logic [3:0] i_page_bits,
	input wire logic i_read_strobe_in,
	input wire logic i_write_strobe_in,
	input wire logic i_addr_latch_strobe,
	input wire logic [7:0] i_low_addr_data_pins,
	input wire logic [7:0] i_porta_pins,
	input wire logic [2:0] i_portc_pins,
	input wire logic i_pgm_we,
	input wire logic [5:0] i_pgm_index,
	input wire logic [15:0] i_pgm_care,
	input wire logic [15:0] i_pgm_match,
	input wire logic i_pgm_enable,
	output logic [7:0] o_eprom_bank_select,
	output logic o_sram_select,
	output logic o_port_space_select,
	output logic [3:0] o_ext_select_wide,
	output logic [3:0] o_ext_select_narrow,
	output logic [2:0] o_ext_select_portc,
	output logic [7:0] o_portb_out,
	output logic [7:0] o_portb_oe,
	output logic [2:0] o_portc_out,
	output logic [2:0] o_portc_oe,
	output logic [7:0] o_low_addr_data_out,
	output logic o_low_addr_data_oe,
	output logic [7:0] o_porta_out,
	output logic o_porta_oe,
	output logic o_power_down
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [pad_pkg::SYN_W-1:0] sync1_ff;
	logic [pad_pkg::SYN_W-1:0] sync2_ff;
	logic [pad_pkg::MODE_W-1:0] mode_ff;

	// sampling pins costs latency but keeps async pins off the terms
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sync1_ff <= 32'h0000_0000;
			sync2_ff <= 32'h0000_0000;
		end else begin
			sync1_ff <= {i_porta_pins, i_low_addr_data_pins, i_portc_pins,
				i_addr_latch_strobe, i_write_strobe_in, i_read_strobe_in,
				i_page_bits, i_standby_or_high_addr, i_addr_high};
			sync2_ff <= sync1_ff;
		end
	end

	// ------------------------------------------------------------
	// configuration
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			mode_ff <= pad_pkg::MODE_RESET;
		end else if (i_pgm_we && i_pgm_index == pad_pkg::IDX_MODE) begin
			mode_ff <= i_pgm_match[pad_pkg::MODE_W-1:0];
		end
	end

	logic standby_mode;
	logic [2:0] portc_dir;
	logic [7:0] portb_route;
	logic track_mode;
	logic [7:0] ad_now;
	logic [7:0] porta_now;
	logic rd_now;
	logic ale_now;
	logic standby_now;
	logic [2:0] high_in;
	logic [pad_pkg::N_IN-1:0] dec_vec;

	always_comb begin
		standby_mode = mode_ff[pad_pkg::MODE_STANDBY];
		portc_dir = mode_ff[pad_pkg::MODE_PORTC_LO +: 3];
		portb_route = mode_ff[pad_pkg::MODE_PORTB_LO +: pad_pkg::PORTB_W];
		track_mode = mode_ff[pad_pkg::MODE_TRACK];
		ad_now = sync2_ff[pad_pkg::SY_AD +: pad_pkg::BUS_W];
		porta_now = sync2_ff[pad_pkg::SY_PORTA +: pad_pkg::BUS_W];
		rd_now = sync2_ff[pad_pkg::SY_RD];
		ale_now = sync2_ff[pad_pkg::SY_ALE];
		standby_now = standby_mode && sync2_ff[pad_pkg::SY_A19];
		// a pin driving a select is not an address input
		high_in = sync2_ff[pad_pkg::SY_PORTC +: 3] & ~portc_dir;
		dec_vec = '0;
		dec_vec[pad_pkg::IN_ADDR_LO +: pad_pkg::IN_ADDR_W] =
			sync2_ff[pad_pkg::SY_ADDR +: pad_pkg::IN_ADDR_W];
		dec_vec[pad_pkg::IN_HIGH_LO +: 3] = high_in;
		// in standby mode the pin is not an address term
		dec_vec[pad_pkg::IN_A19] = sync2_ff[pad_pkg::SY_A19] && !standby_mode;
		dec_vec[pad_pkg::IN_PAGE_LO +: pad_pkg::IN_PAGE_W] =
			sync2_ff[pad_pkg::SY_PAGE +: pad_pkg::IN_PAGE_W];
		dec_vec[pad_pkg::IN_READ] = rd_now;
		dec_vec[pad_pkg::IN_WRITE] = sync2_ff[pad_pkg::SY_WR];
		dec_vec[pad_pkg::IN_ALE] = ale_now;
	end

	// ------------------------------------------------------------
	// product term array
	// ------------------------------------------------------------
	logic [pad_pkg::N_PT-1:0] hit;

	// one vector feeds every term of both arrays; reset is not in it
	genvar gt;
	generate
		for (gt = 0; gt < pad_pkg::N_PT; gt++) begin : g_term
			pad_product_term u_term (
				.i_clk_sys(i_clk_sys),
				.i_rst(i_rst),
				.i_we(i_pgm_we && i_pgm_index == 6'(gt)),
				.i_care(i_pgm_care),
				.i_match(i_pgm_match),
				.i_enable(i_pgm_enable),
				.i_vec(dec_vec),
				.o_hit(hit[gt])
			);
		end
	endgenerate

	logic [3:0] wide_or;
	logic [3:0] narrow_or;
	genvar gw;
	generate
		for (gw = 0; gw < pad_pkg::N_WIDE; gw++) begin : g_wide
			assign wide_or[gw] = |hit[pad_pkg::PT_WIDE + gw*pad_pkg::N_WIDE_PT +: pad_pkg::N_WIDE_PT];
			assign narrow_or[gw] =
				|hit[pad_pkg::PT_NARROW + gw*pad_pkg::N_NARROW_PT +: pad_pkg::N_NARROW_PT];
		end
	endgenerate

	// ------------------------------------------------------------
	// select outputs
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_eprom_bank_select <= 8'h00;
			o_sram_select <= 1'b0;
			o_port_space_select <= 1'b0;
			o_ext_select_wide <= 4'h0;
			o_ext_select_narrow <= 4'h0;
			o_ext_select_portc <= 3'h0;
			o_power_down <= 1'b0;
		end else if (standby_now) begin
			o_eprom_bank_select <= 8'h00;
			o_sram_select <= 1'b0;
			o_port_space_select <= 1'b0;
			o_ext_select_wide <= 4'h0;
			o_ext_select_narrow <= 4'h0;
			o_ext_select_portc <= 3'h0;
			o_power_down <= 1'b1;
		end else begin
			o_eprom_bank_select <= hit[pad_pkg::PT_EPROM +: pad_pkg::N_EPROM];
			o_sram_select <= hit[pad_pkg::PT_SRAM];
			o_port_space_select <= hit[pad_pkg::PT_IOSPACE];
			o_ext_select_wide <= wide_or;
			o_ext_select_narrow <= narrow_or;
			o_ext_select_portc <= hit[pad_pkg::PT_PORTC +: pad_pkg::N_PORTC];
			o_power_down <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// port b and port c pins
	// ------------------------------------------------------------
	// pins carry selects active low; deselected pins idle high
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_portb_out <= 8'hFF;
			o_portb_oe <= 8'h00;
			o_portc_out <= 3'h7;
			o_portc_oe <= 3'h0;
		end else if (standby_now) begin
			o_portb_out <= 8'hFF;
			o_portb_oe <= portb_route;
			o_portc_out <= 3'h7;
			o_portc_oe <= portc_dir;
		end else begin
			o_portb_out <= ~{narrow_or, wide_or};
			o_portb_oe <= portb_route;
			o_portc_out <= ~hit[pad_pkg::PT_PORTC +: pad_pkg::N_PORTC];
			o_portc_oe <= portc_dir;
		end
	end

	// ------------------------------------------------------------
	// track mode path
	// ------------------------------------------------------------
	logic trk_rd;
	logic trk_ao;
	logic trk_wo;

	always_comb begin
		trk_ao = track_mode && !standby_now && hit[pad_pkg::PT_TRACK_AO] && ale_now;
		// write terms live inside the term itself
		trk_wo = track_mode && !standby_now && hit[pad_pkg::PT_TRACK_WO];
		// port a drive wins so the two buffers never face each other
		trk_rd = track_mode && !standby_now && hit[pad_pkg::PT_TRACK_RD] && rd_now
			&& !trk_ao && !trk_wo;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_porta_out <= 8'h00;
			o_porta_oe <= 1'b0;
			o_low_addr_data_out <= 8'h00;
			o_low_addr_data_oe <= 1'b0;
		end else begin
			o_porta_out <= (trk_ao || trk_wo) ? ad_now : 8'h00;
			o_porta_oe <= trk_ao || trk_wo;
			o_low_addr_data_out <= trk_rd ? porta_now : 8'h00;
			o_low_addr_data_oe <= trk_rd;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	property p_standby_clear;
		standby_now |=> (o_eprom_bank_select == 8'h00) && !o_sram_select && !o_port_space_select
			&& (o_ext_select_wide == 4'h0) && o_power_down && !o_porta_oe;
	endproperty
	a_standby_clear: assert property (p_standby_clear) else $error("standby left a select active");

	property p_eprom;
		!standby_now |=> o_eprom_bank_select == $past(hit[7:0]);
	endproperty
	a_eprom: assert property (p_eprom) else $error("eprom select mismatch");

	property p_sram;
		(!standby_now && hit[pad_pkg::PT_SRAM]) |=> o_sram_select;
	endproperty
	a_sram: assert property (p_sram) else $error("sram select missed");

	property p_iospace;
		(!standby_now && !hit[pad_pkg::PT_IOSPACE]) |=> !o_port_space_select;
	endproperty
	a_iospace: assert property (p_iospace) else $error("port space select spurious");

	property p_track_read;
		trk_rd |=> o_low_addr_data_oe && (o_low_addr_data_out == $past(porta_now));
	endproperty
	a_track_read: assert property (p_track_read) else $error("track read not driven");

	property p_track_addr;
		trk_ao |=> o_porta_oe && (o_porta_out == $past(ad_now));
	endproperty
	a_track_addr: assert property (p_track_addr) else $error("track address not driven");

	property p_wide;
		!standby_now |=> o_ext_select_wide[0] == $past(|hit[16:13]);
	endproperty
	a_wide: assert property (p_wide) else $error("wide select not or of four");

	property p_narrow;
		!standby_now |=> o_ext_select_narrow[3] == $past(|hit[36:35]);
	endproperty
	a_narrow: assert property (p_narrow) else $error("narrow select not or of two");

	// tie the pins to the terms, not only to the select flops
	property p_portc;
		!standby_now |=> (o_ext_select_portc == $past(hit[pad_pkg::PT_PORTC +: pad_pkg::N_PORTC]))
			&& (o_portc_out == ~o_ext_select_portc);
	endproperty
	a_portc: assert property (p_portc) else $error("port c pins disagree");

	property p_idle;
		!(trk_ao || trk_wo || trk_rd) |=> !o_porta_oe && !o_low_addr_data_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("track path driven while idle");

	property p_no_fight;
		!(o_porta_oe && o_low_addr_data_oe);
	endproperty
	a_no_fight: assert property (p_no_fight) else $error("both track buffers on");

	c_standby: cover property (standby_now ##1 o_power_down);
	c_track_write: cover property (trk_wo ##1 o_porta_oe);
	c_track_read: cover property (trk_rd ##1 o_low_addr_data_oe);
	c_eprom: cover property (o_eprom_bank_select != 8'h00);
endmodule : pad_decoder

// File: bench/pad_mcu_model.sv
// microcontroller bus and port pin model facing the address decoder
`timescale 1ns/1ps
module pad_mcu_model (
	input wire logic i_clk_sys,
	output logic [4:0] o_addr_high,
	output logic o_standby_or_high_addr,
	output logic [3:0] o_page_bits,
	output logic o_read_strobe_in,
	output logic o_write_strobe_in,
	output logic o_addr_latch_strobe,
	output logic [7:0] o_low_addr_data_pins,
	output logic [7:0] o_porta_pins,
	output logic [2:0] o_portc_pins
);
	logic [7:0] last_ad;
	initial begin
		o_addr_high = 5'h00;
		o_standby_or_high_addr = 1'b0;
		o_page_bits = 4'h0;
		o_read_strobe_in = 1'b0;
		o_write_strobe_in = 1'b0;
		o_addr_latch_strobe = 1'b0;
		o_low_addr_data_pins = 8'h00;
		o_porta_pins = 8'h00;
		o_portc_pins = 3'h0;
		last_ad = 8'h00;
	end
	// ------------------------------------------------------------
	// bus phase, ctl is {latch, write, read}
	// ------------------------------------------------------------
	task bus(input logic [4:0] a, input logic [3:0] pg, input logic [2:0] ctl,
		input logic [7:0] ad);
		@(negedge i_clk_sys);
		o_addr_high = a;
		o_page_bits = pg;
		o_read_strobe_in = ctl[0];
		o_write_strobe_in = ctl[1];
		o_addr_latch_strobe = ctl[2];
		// mcu drives the inverse of its last value while reading: no stale value shows
		if (ctl[0]) begin
			o_low_addr_data_pins = ~last_ad;
		end else begin
			o_low_addr_data_pins = ad;
			last_ad = ad;
		end
	endtask : bus
	task pins(input logic a19, input logic [7:0] pa, input logic [2:0] pc);
		@(negedge i_clk_sys);
		o_standby_or_high_addr = a19;
		o_porta_pins = pa;
		o_portc_pins = pc;
	endtask : pins
endmodule : pad_mcu_model

// File: bench/tb_pad_decoder.sv
// self-checking testbench for the programmable address decoder
`timescale 1ns/1ps
module tb_pad_decoder;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pgm_we = 1'b0;
	logic [5:0] pgm_index = 6'h00;
	logic [15:0] pgm_care = 16'h0000;
	logic [15:0] pgm_match = 16'h0000;
	logic pgm_enable = 1'b0;
	logic [4:0] addr_high;
	logic a19, rd, wr, ale;
	logic [3:0] page_bits;
	logic [7:0] ad_in, pa_in, ad_out, porta_out, eprom_sel, portb_out, portb_oe;
	logic [2:0] pc_in, ext_portc, portc_out, portc_oe;
	logic [3:0] ext_wide, ext_narrow;
	logic sram_sel, port_sel, ad_oe, porta_oe, power_down;
	int n_errors = 0;
	int comparisons = 0;
	always #50 clk = ~clk;
	pad_mcu_model i_mcu (.i_clk_sys(clk), .o_addr_high(addr_high),
		.o_standby_or_high_addr(a19), .o_page_bits(page_bits), .o_read_strobe_in(rd),
		.o_write_strobe_in(wr), .o_addr_latch_strobe(ale), .o_low_addr_data_pins(ad_in),
		.o_porta_pins(pa_in), .o_portc_pins(pc_in));
	pad_decoder i_dut (.i_clk_sys(clk), .i_rst(rst), .i_addr_high(addr_high),
		.i_standby_or_high_addr(a19), .i_page_bits(page_bits), .i_read_strobe_in(rd),
		.i_write_strobe_in(wr), .i_addr_latch_strobe(ale), .i_low_addr_data_pins(ad_in),
		.i_porta_pins(pa_in), .i_portc_pins(pc_in), .i_pgm_we(pgm_we),
		.i_pgm_index(pgm_index), .i_pgm_care(pgm_care), .i_pgm_match(pgm_match),
		.i_pgm_enable(pgm_enable), .o_eprom_bank_select(eprom_sel), .o_sram_select(sram_sel),
		.o_port_space_select(port_sel), .o_ext_select_wide(ext_wide),
		.o_ext_select_narrow(ext_narrow), .o_ext_select_portc(ext_portc),
		.o_portb_out(portb_out), .o_portb_oe(portb_oe), .o_portc_out(portc_out),
		.o_portc_oe(portc_oe), .o_low_addr_data_out(ad_out), .o_low_addr_data_oe(ad_oe),
		.o_porta_out(porta_out), .o_porta_oe(porta_oe), .o_power_down(power_down));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task pgm(input logic [5:0] idx, input logic [15:0] care, input logic [15:0] match);
		@(negedge clk);
		pgm_we = 1'b1;
		pgm_index = idx;
		pgm_care = care;
		pgm_match = match;
		pgm_enable = 1'b1;
		@(negedge clk);
		pgm_we = 1'b0;
	endtask : pgm
	// pins pass two sync flops and an output flop, so four edges is enough
	task settle();
		repeat (4) @(negedge clk);
	endtask : settle
	task do_reset();
		@(negedge clk);
		rst = 1'b1;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
	endtask : do_reset
	task stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_reset();
		// an always-true term makes reset clear a live select
		pgm(6'h00, 16'h0000, 16'h0000);
		settle();
		chk(eprom_sel, 8'h01);
		rst = 1'b1;
		settle();
		chk({eprom_sel, sram_sel, port_sel, ext_wide, ext_narrow, ext_portc, power_down,
			porta_oe, ad_oe}, 32'h0);
		chk({portb_out, portb_oe, portc_out, portc_oe}, {10'h0, 8'hFF, 8'h00, 3'h7, 3'h0});
		$display("test reset done");
	endtask : t_reset
	task t_internal();
		do_reset();
		for (int s = 0; s < 10; s++) begin
			// page bits take part too, so the internal array sees them
			pgm(s[5:0], 16'h1E1F, 16'h1400 | s[15:0]);
			i_mcu.bus(s[4:0], 4'hA, 3'b000, 8'h00);
			settle();
			chk({port_sel, sram_sel, eprom_sel}, 32'h1 << s);
		end
		$display("test internal done");
	endtask : t_internal
	task t_external();
		logic [10:0] e;
		do_reset();
		for (int s = 13; s < 40; s++) begin
			pgm(s[5:0], 16'h001F, 16'(s - 13));
			i_mcu.bus(5'(s - 13), 4'h0, 3'b000, 8'h00);
			settle();
			e = (s < 29) ? 11'h1 << ((s - 13) / 4) :
				(s < 37) ? 11'h10 << ((s - 29) / 2) : 11'h100 << (s - 37);
			chk({ext_portc, ext_narrow, ext_wide}, e);
			chk(portb_out, e[7:0] ^ 8'hFF);
			chk(portc_out, e[10:8] ^ 3'h7);
		end
		$display("test external done");
	endtask : t_external
	task t_strobes();
		do_reset();
		for (int b = 0; b < 3; b++) begin
			pgm(6'h08, 16'h2000 << b, 16'h2000 << b);
			i_mcu.bus(5'h00, 4'h0, 3'b001 << b, 8'h00);
			settle();
			chk(sram_sel, 1'b1);
			i_mcu.bus(5'h00, 4'h0, 3'b000, 8'h00);
			settle();
			chk(sram_sel, 1'b0);
		end
		$display("test strobes done");
	endtask : t_strobes
	task t_track();
		do_reset();
		pgm(6'h28, 16'h0000, 16'h1000);
		pgm(6'h0A, 16'h001F, 16'h0001);
		pgm(6'h0B, 16'h001F, 16'h0002);
		pgm(6'h0C, 16'h401F, 16'h4003);
		i_mcu.pins(1'b0, 8'h3C, 3'h0);
		i_mcu.bus(5'h02, 4'h0, 3'b100, 8'hA5);
		settle();
		chk({porta_oe, porta_out, ad_oe}, {1'b1, 8'hA5, 1'b0});
		i_mcu.bus(5'h02, 4'h0, 3'b000, 8'hA5);
		settle();
		chk({porta_oe, ad_oe}, 2'b00);
		i_mcu.bus(5'h03, 4'h0, 3'b010, 8'h5A);
		settle();
		chk({porta_oe, porta_out, ad_oe}, {1'b1, 8'h5A, 1'b0});
		i_mcu.bus(5'h01, 4'h0, 3'b001, 8'h00);
		settle();
		chk({ad_oe, ad_out, porta_oe}, {1'b1, 8'h3C, 1'b0});
		i_mcu.bus(5'h01, 4'h0, 3'b000, 8'h00);
		settle();
		chk({porta_oe, ad_oe}, 2'b00);
		$display("test track done");
	endtask : t_track
	task t_standby();
		do_reset();
		pgm(6'h28, 16'h0000, 16'h0001);
		pgm(6'h00, 16'h001F, 16'h0000);
		i_mcu.pins(1'b0, 8'h00, 3'h0);
		i_mcu.bus(5'h00, 4'h0, 3'b000, 8'h00);
		settle();
		chk({power_down, eprom_sel}, 9'h001);
		i_mcu.pins(1'b1, 8'h00, 3'h0);
		settle();
		chk({power_down, eprom_sel}, 9'h100);
		do_reset();
		pgm(6'h01, 16'h0100, 16'h0100);
		settle();
		chk(eprom_sel, 8'h02);
		$display("test standby done");
	endtask : t_standby
	task t_ports();
		do_reset();
		// pin 0 is high but drives a select, so its term must stay quiet
		i_mcu.pins(1'b0, 8'h00, 3'b011);
		pgm(6'h28, 16'h0000, 16'h0F0A);
		pgm(6'h02, 16'h0040, 16'h0040);
		pgm(6'h03, 16'h0020, 16'h0020);
		settle();
		chk({portb_oe, portc_oe, eprom_sel}, {8'hF0, 3'h5, 8'h04});
		chk(portc_out, 3'h7);
		$display("test ports done");
	endtask : t_ports
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		do_reset();
		t_reset();
		t_internal();
		t_external();
		t_strobes();
		t_track();
		t_standby();
		t_ports();
		stop_test();
	end
	// run needs well under 2000 cycles, so a tenfold margin
	initial begin
		#2000000;
		n_errors++;
		stop_test();
	end
endmodule : tb_pad_decoder
